// ---- src/pfc_control.sv ----
/*
 * pfc_control: register file and frequency-change control of a fractional-N
 * synthesizer: integer and fractional loads with or without VCO
 * self-calibration, output mute, charge pump settings and detector gating.
 * Assumes an outside measurement engine that answers cal_start with
 * cal_done and the chosen switch setting, both timed by cal_tick.
 */
`timescale 1ns/1ps
module pfc_control
   import pfc_pkg::*;
#(
   parameter int TICK_SEL_W = 2
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // main serial port
   input  wire logic                sen,
   input  wire logic                sck,
   input  wire logic                sdi,
   output logic                     sdo,
   // calibration engine
   output logic                     cal_tick,
   output logic                     cal_start,
   input  wire logic                cal_done,
   input  wire logic [SW_W-1:0]     cal_switch,
   // divider and vco settings
   output logic [DATA_W-1:0]        prescaler_int,
   output logic [DATA_W-1:0]        dsm_frac,
   output logic [SW_W-1:0]          vco_switch,
   output logic [OUTDIV_W-1:0]      out_divide,
   // output gating
   output logic                     out_mute,
   output logic [1:0]               out_buf_en,
   // charge pump settings
   output logic [GAIN_W-1:0]        cp_up_gain,
   output logic [GAIN_W-1:0]        cp_dn_gain,
   output logic [GAIN_W-1:0]        pump_bias_current,
   output logic                     pump_bias_up_en,
   output logic                     pump_bias_dn_en,
   // phase detector to charge pump
   input  wire logic                phase_detector_up,
   input  wire logic                phase_detector_dn,
   output logic                     charge_pump_up,
   output logic                     charge_pump_dn,
   output logic                     charge_pump_hiz
);
   initial begin
      if (TICK_SEL_W != 2) $error("pfc_control: divider field is two bits");
   end

   // register file
   logic [DATA_W-1:0] integer_divide;          // host integer value
   logic [DATA_W-1:0] fractional;              // host fractional value
   logic [DATA_W-1:0] synth_mode_config;
   logic [DATA_W-1:0] pump_gain_offset;
   logic [DATA_W-1:0] vco_calibration_config;
   logic [DATA_W-1:0] phase_detector_control;
   logic [DATA_W-1:0] vco_manual_tuning;
   logic [DATA_W-1:0] vco_output_divider;
   logic [DATA_W-1:0] vco_output_control;

   // serial side
   logic              wr_pulse;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;

   // sequencing
   pfc_cal_state_t    cal_state;
   logic              frac_mode;
   logic              cal_off;
   logic              wr_int;
   logic              wr_frac;
   logic              trigger;    // write that starts the change sequence
   logic              cal_busy;

   // readback decode, shared by the read path
   function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] a);
      unique case (a)
         ADR_INTEGER_DIVIDE: reg_read = integer_divide;
         ADR_FRACTIONAL:     reg_read = fractional;
         ADR_SYNTH_MODE:     reg_read = synth_mode_config;
         ADR_PUMP_GAIN_OFS:  reg_read = pump_gain_offset;
         ADR_VCO_CAL_CFG:    reg_read = vco_calibration_config;
         ADR_PHASE_DET_CTL:  reg_read = phase_detector_control;
         ADR_VCO_MAN_TUNE:   reg_read = vco_manual_tuning;
         ADR_VCO_OUT_DIV:    reg_read = vco_output_divider;
         ADR_VCO_OUT_CTL:    reg_read = vco_output_control;
         default:            reg_read = RST_ZERO;   // unmapped reads zero
      endcase
   endfunction

   assign rd_data = reg_read(rd_addr);

   pfc_serial_slave u_port (
      .clk      (clk),
      .resetn   (resetn),
      .sen      (sen),
      .sck      (sck),
      .sdi      (sdi),
      .sdo      (sdo),
      .wr_pulse (wr_pulse),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data)
   );

   // fsm clock for the calibration engine
   pfc_tick_div #(.SEL_W(TICK_SEL_W)) u_tick (
      .clk    (clk),
      .resetn (resetn),
      .sel    (vco_calibration_config[CAL_TICK_HI:CAL_TICK_LO]),
      .tick   (cal_tick)
   );

   assign frac_mode = synth_mode_config[MODE_FRAC_BIT];
   assign cal_off   = vco_calibration_config[CAL_DIS_BIT];
   assign wr_int    = wr_pulse && wr_addr == ADR_INTEGER_DIVIDE;
   assign wr_frac   = wr_pulse && wr_addr == ADR_FRACTIONAL;
   assign trigger   = frac_mode ? wr_frac : wr_int;
   assign cal_busy  = cal_state != PFC_CAL_IDLE;

   // plain register writes; the tuning register is handled below
   always_ff @(posedge clk) begin
      if (!resetn) begin
         integer_divide         <= RST_ZERO;
         fractional             <= RST_ZERO;
         synth_mode_config      <= RST_ZERO;
         pump_gain_offset       <= RST_ZERO;
         vco_calibration_config <= RST_ZERO;
         phase_detector_control <= RST_PHASE_DET_CTL;
         vco_output_divider     <= RST_ZERO;
         vco_output_control     <= RST_ZERO;
      end else if (wr_pulse) begin
         unique case (wr_addr)
            ADR_INTEGER_DIVIDE: integer_divide         <= wr_data;
            ADR_FRACTIONAL:     fractional             <= wr_data;
            ADR_SYNTH_MODE:     synth_mode_config      <= wr_data;
            ADR_PUMP_GAIN_OFS:  pump_gain_offset       <= wr_data;
            ADR_VCO_CAL_CFG:    vco_calibration_config <= wr_data;
            ADR_PHASE_DET_CTL:  phase_detector_control <= wr_data;
            ADR_VCO_OUT_DIV:    vco_output_divider     <= wr_data;
            ADR_VCO_OUT_CTL:    vco_output_control     <= wr_data;
            default: ;   // unmapped or tuning register
         endcase
      end
   end

   // calibrated switch readback
   // a finishing calibration wins over a host write in the same cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         vco_manual_tuning <= RST_ZERO;
      end else if (cal_state == PFC_CAL_MEASURE && cal_done) begin
         vco_manual_tuning[SW_HI:SW_LO] <= cal_switch;
      end else if (wr_pulse && wr_addr == ADR_VCO_MAN_TUNE) begin
         vco_manual_tuning <= wr_data;
      end
   end

   // calibration sequencer
   // later triggers during the measurement only refresh the value to be loaded
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cal_state <= PFC_CAL_IDLE;
         cal_start <= 1'b0;
      end else begin
         cal_start <= 1'b0;
         unique case (cal_state)
            PFC_CAL_IDLE: begin
               if (trigger && !cal_off) begin
                  cal_state <= PFC_CAL_MEASURE;
                  cal_start <= 1'b1;
               end
            end
            PFC_CAL_MEASURE: begin
               if (cal_done) cal_state <= PFC_CAL_LOAD;
            end
            PFC_CAL_LOAD: begin
               cal_state <= PFC_CAL_IDLE;
            end
            // unused code: recover to idle
            default: cal_state <= PFC_CAL_IDLE;
         endcase
      end
   end

   // prescaler and modulator loads
   // immediate for either register when calibration is off and idle, else at the load state for the register of the current mode only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prescaler_int <= RST_ZERO;
         dsm_frac      <= RST_ZERO;
      end else if (cal_state == PFC_CAL_LOAD) begin
         if (frac_mode) dsm_frac <= fractional;
         else           prescaler_int <= integer_divide;
      end else if (cal_off && !cal_busy) begin
         if (wr_int) prescaler_int <= wr_data;
         if (wr_frac) dsm_frac <= wr_data;
      end
   end

   // switch setting: manual writes apply at once only with calibration off
   always_ff @(posedge clk) begin
      if (!resetn) begin
         vco_switch <= '0;
      end else if (cal_state == PFC_CAL_MEASURE && cal_done) begin
         vco_switch <= cal_switch;
      end else if (cal_off && wr_pulse && wr_addr == ADR_VCO_MAN_TUNE) begin
         vco_switch <= wr_data[SW_HI:SW_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         out_mute   <= 1'b1;
         out_divide <= '0;
         out_buf_en <= 2'h0;
      end else begin
         out_divide <= vco_output_divider[OUT_DIV_HI:OUT_DIV_LO];
         out_mute   <= (vco_output_divider[OUT_DIV_HI:OUT_DIV_LO] == OUT_DIV_MUTE)
                       || (vco_output_control[AUTO_MUTE_BIT] && cal_busy);
         out_buf_en <= vco_output_control[BUF_EN_HI:BUF_EN_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cp_up_gain        <= '0;
         cp_dn_gain        <= '0;
         pump_bias_current <= '0;
         pump_bias_up_en   <= 1'b0;
         pump_bias_dn_en   <= 1'b0;
      end else begin
         cp_up_gain        <= pump_gain_offset[UP_GAIN_HI:UP_GAIN_LO];
         cp_dn_gain        <= pump_gain_offset[DN_GAIN_HI:DN_GAIN_LO];
         pump_bias_current <= pump_gain_offset[OFS_MAG_HI:OFS_MAG_LO];
         pump_bias_up_en   <= pump_gain_offset[OFS_UP_BIT];
         pump_bias_dn_en   <= pump_gain_offset[OFS_DN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         charge_pump_up  <= 1'b0;
         charge_pump_dn  <= 1'b0;
         charge_pump_hiz <= 1'b1;
      end else begin
         charge_pump_up  <= phase_detector_control[PHASE_FORCE_RAISE_BIT]
                            || (phase_detector_up && phase_detector_control[PD_UP_EN_BIT]);
         charge_pump_dn  <= phase_detector_control[PHASE_FORCE_LOWER_BIT]
                            || (phase_detector_dn && phase_detector_control[PD_DN_EN_BIT]);
         // forcing overrides the tri-state
         charge_pump_hiz <= !phase_detector_control[PD_UP_EN_BIT]
                            && !phase_detector_control[PD_DN_EN_BIT]
                            && !phase_detector_control[PHASE_FORCE_RAISE_BIT]
                            && !phase_detector_control[PHASE_FORCE_LOWER_BIT];
      end
   end

   // checks
   property p_cal_starts;
      @(posedge clk) disable iff (!resetn)
      (trigger && !cal_off && !cal_busy) |=> cal_start && cal_state == PFC_CAL_MEASURE;
   endproperty
   a_cal_starts: assert property (p_cal_starts) else $error("no calibration start");

   property p_hold_int;
      @(posedge clk) disable iff (!resetn)
      (cal_state == PFC_CAL_MEASURE && !frac_mode) |=> $stable(prescaler_int);
   endproperty
   a_hold_int: assert property (p_hold_int) else $error("prescaler moved in calibration");

   property p_load_after;
      @(posedge clk) disable iff (!resetn)
      (cal_state == PFC_CAL_MEASURE && cal_done && !frac_mode)
         |=> ##1 prescaler_int == $past(integer_divide, 1);
   endproperty
   a_load_after: assert property (p_load_after) else $error("prescaler not loaded");

   property p_immediate;
      @(posedge clk) disable iff (!resetn)
      (wr_int && cal_off && !cal_busy) |=> prescaler_int == $past(wr_data) && $stable(vco_switch);
   endproperty
   a_immediate: assert property (p_immediate) else $error("integer not immediate");

   property p_mute_zero;
      @(posedge clk) disable iff (!resetn)
      (vco_output_divider[OUT_DIV_HI:OUT_DIV_LO] == OUT_DIV_MUTE) |=> out_mute;
   endproperty
   a_mute_zero: assert property (p_mute_zero) else $error("zero divider not muted");

   property p_auto_mute;
      @(posedge clk) disable iff (!resetn)
      (cal_start && vco_output_control[AUTO_MUTE_BIT]) |=> out_mute [*2];
   endproperty
   a_auto_mute: assert property (p_auto_mute) else $error("auto-mute missing");

   property p_up_block;
      @(posedge clk) disable iff (!resetn)
      (!phase_detector_control[PD_UP_EN_BIT] && !phase_detector_control[PHASE_FORCE_RAISE_BIT])
         |=> !charge_pump_up;
   endproperty
   a_up_block: assert property (p_up_block) else $error("masked up pulse passed");

   property p_dn_block;
      @(posedge clk) disable iff (!resetn)
      (!phase_detector_control[PD_DN_EN_BIT] && !phase_detector_control[PHASE_FORCE_LOWER_BIT])
         |=> !charge_pump_dn;
   endproperty
   a_dn_block: assert property (p_dn_block) else $error("masked down pulse passed");

   property p_force;
      @(posedge clk) disable iff (!resetn)
      phase_detector_control[PHASE_FORCE_RAISE_BIT] |=> charge_pump_up && !charge_pump_hiz;
   endproperty
   a_force: assert property (p_force) else $error("force up ignored");

   property p_readback;
      @(posedge clk) disable iff (!resetn)
      (cal_state == PFC_CAL_MEASURE && cal_done)
         |=> vco_manual_tuning[SW_HI:SW_LO] == $past(cal_switch) && vco_switch == $past(cal_switch);
   endproperty
   a_readback: assert property (p_readback) else $error("switch not readable");

   c_cal_cycle: cover property (@(posedge clk) disable iff (!resetn)
      cal_start ##[1:50] cal_state == PFC_CAL_LOAD);
   c_direct_load: cover property (@(posedge clk) disable iff (!resetn) wr_int && cal_off);
   c_hiz: cover property (@(posedge clk) disable iff (!resetn) charge_pump_hiz ##1 !charge_pump_hiz);
endmodule // pfc_control

// ---- src/pfc_pkg.sv ----
/*
 * pfc_pkg: register map, field positions, reset values and state encoding for the
 * synthesizer frequency-change, mute, charge pump and phase detector control.
 * Assumes a 24-bit register file reached over the main serial port.
 */
package pfc_pkg;
   // serial frame layout: read flag, 6-bit address, 24-bit data
   localparam int ADDR_W     = 6;
   localparam int DATA_W     = 24;
   localparam int FRAME_BITS = 1 + ADDR_W + DATA_W;
   localparam int HDR_BITS   = 1 + ADDR_W;

   // register offsets
   localparam logic [5:0] ADR_INTEGER_DIVIDE = 6'h03;
   localparam logic [5:0] ADR_FRACTIONAL     = 6'h04;
   localparam logic [5:0] ADR_SYNTH_MODE     = 6'h06;
   localparam logic [5:0] ADR_PUMP_GAIN_OFS  = 6'h09;
   localparam logic [5:0] ADR_VCO_CAL_CFG    = 6'h0A;
   localparam logic [5:0] ADR_PHASE_DET_CTL  = 6'h0B;
   localparam logic [5:0] ADR_VCO_MAN_TUNE   = 6'h15;
   localparam logic [5:0] ADR_VCO_OUT_DIV    = 6'h16;
   localparam logic [5:0] ADR_VCO_OUT_CTL    = 6'h17;

   // field positions
   localparam int MODE_FRAC_BIT   = 11;   // synth mode: 1 = fractional
   localparam int CAL_DIS_BIT     = 11;   // cal config: 1 = self-cal off
   localparam int CAL_TICK_HI     = 14;   // cal config: fsm clock divider
   localparam int CAL_TICK_LO     = 13;
   localparam int UP_GAIN_HI      = 13;
   localparam int UP_GAIN_LO      = 7;
   localparam int DN_GAIN_HI      = 6;
   localparam int DN_GAIN_LO      = 0;
   localparam int OFS_MAG_HI      = 20;
   localparam int OFS_MAG_LO      = 14;
   localparam int OFS_UP_BIT      = 21;
   localparam int OFS_DN_BIT      = 22;
   localparam int PD_UP_EN_BIT    = 5;
   localparam int PD_DN_EN_BIT    = 6;
   localparam int PHASE_FORCE_RAISE_BIT = 9;
   localparam int PHASE_FORCE_LOWER_BIT = 10;
   localparam int SW_HI           = 8;    // manual tuning: switch setting
   localparam int SW_LO           = 1;
   localparam int OUT_DIV_HI      = 5;
   localparam int OUT_DIV_LO      = 0;
   localparam int AUTO_MUTE_BIT   = 7;
   localparam int BUF_EN_HI       = 5;
   localparam int BUF_EN_LO       = 4;

   localparam int GAIN_W   = 7;
   localparam int SW_W     = 8;
   localparam int OUTDIV_W = 6;

   // reset values: detector up and down paths unmasked
   localparam logic [23:0] RST_PHASE_DET_CTL = 24'h000060;
   localparam logic [23:0] RST_ZERO          = 24'h000000;
   // gain code for one milliamp per pump; current scales linearly with code
   localparam logic [6:0]  GAIN_CODE_1MA     = 7'h32;
   localparam logic [5:0]  OUT_DIV_MUTE      = 6'h00;

   typedef enum logic [1:0] {PFC_CAL_IDLE, PFC_CAL_MEASURE, PFC_CAL_LOAD} pfc_cal_state_t;
endpackage

// ---- src/pfc_tick_div.sv ----
/*
 * pfc_tick_div: one-cycle enable pulse every 2**sel clocks; this is the
 * calibration state machine clock. Assumes sel is static between uses.
 */
`timescale 1ns/1ps
module pfc_tick_div #(
   parameter int SEL_W = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // divider select and tick
   input  wire logic [SEL_W-1:0] sel,
   output logic                  tick
);
   localparam int CNT_W = 1 << SEL_W;
   initial begin
      if (SEL_W < 1 || SEL_W > 4) $error("pfc_tick_div: SEL_W out of range");
   end

   logic [CNT_W-1:0] count;   // free-running prescale counter
   logic [CNT_W-1:0] mask;    // low bits that must be all ones

   always_comb begin
      mask = CNT_W'((64'h1 << sel) - 64'h1);
   end

   // counter advances every cycle; wraps naturally
   always_ff @(posedge clk) begin
      if (!resetn) begin
         count <= '0;
      end else begin
         count <= count + CNT_W'(1);
      end
   end

   // tick when the selected low bits are all ones
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tick <= 1'b0;
      end else begin
         tick <= ((count & mask) == mask);
      end
   end
endmodule // pfc_tick_div

// ---- src/pfc_serial_slave.sv ----
/*
 * pfc_serial_slave: main serial port. Frame while sen is high: read flag,
 * address msb first, then 24 data bits msb first. Pins are synchronous to
 * clk; sck must stay high and low for at least two clk cycles each.
 */
`timescale 1ns/1ps
module pfc_serial_slave
   import pfc_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // serial pins
   input  wire logic              sen,
   input  wire logic              sck,
   input  wire logic              sdi,
   output logic                   sdo,
   // register side
   output logic                   wr_pulse,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic [DATA_W-1:0]      wr_data,
   output logic [ADDR_W-1:0]      rd_addr,
   input  wire logic [DATA_W-1:0] rd_data
);
   logic                  sck_d;     // previous sck level
   logic                  sen_d;     // previous sen level
   logic [FRAME_BITS-1:0] shift_in;  // received bits
   logic [5:0]            nbits;     // bits seen, saturating
   logic [DATA_W-1:0]     shift_out; // read data
   logic                  rise;

   assign rise = sen && sck && !sck_d;
   assign rd_addr = shift_in[ADDR_W-1:0];

   // edge history
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sck_d <= 1'b0;
         sen_d <= 1'b0;
      end else begin
         sck_d <= sck;
         sen_d <= sen;
      end
   end

   // shift in on sck rise; frame start clears the count
   always_ff @(posedge clk) begin
      if (!resetn) begin
         shift_in <= '0;
         nbits    <= '0;
      end else if (sen && !sen_d) begin
         nbits <= '0;
      end else if (rise) begin
         shift_in <= {shift_in[FRAME_BITS-2:0], sdi};
         // saturate so an over-long frame never looks complete
         if (nbits != 6'h3F) nbits <= nbits + 6'h01;
      end
   end

   // commit at frame end
   // only an exact-length write frame commits, on sen fall
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_pulse <= 1'b0;
         wr_addr  <= '0;
         wr_data  <= '0;
      end else begin
         wr_pulse <= !sen && sen_d && (nbits == 6'(FRAME_BITS))
                     && !shift_in[FRAME_BITS-1];
         wr_addr  <= shift_in[FRAME_BITS-2:DATA_W];
         wr_data  <= shift_in[DATA_W-1:0];
      end
   end

   // read data loaded after the header, then shifted out msb first
   always_ff @(posedge clk) begin
      if (!resetn) begin
         shift_out <= '0;
         sdo       <= 1'b0;
      end else if (sen && nbits == 6'(HDR_BITS) && sck_d && !sck
                   && shift_in[ADDR_W]) begin
         shift_out <= {rd_data[DATA_W-2:0], 1'b0};
         sdo       <= rd_data[DATA_W-1];
      end else if (sen && nbits > 6'(HDR_BITS) && sck_d && !sck) begin
         sdo       <= shift_out[DATA_W-1];
         shift_out <= {shift_out[DATA_W-2:0], 1'b0};
      end else if (!sen) begin
         sdo <= 1'b0;
      end
   end
endmodule // pfc_serial_slave

// ---- verification/pfc_cal_model.sv ----
/* pfc_cal_model: stand-in for the calibration engine.
   assumes one cal_start pulse per calibration. */
`timescale 1ns/1ps
module pfc_cal_model (
   // clock and start
   input  wire logic       clk,
   input  wire logic       cal_start,
   input  wire logic [7:0] sw_val,
   // answer
   output logic            cal_done = 1'b0,
   output logic [7:0]      cal_switch = 8'h00
);
   int cnt = 0; // cycles left to answer
   always @(posedge clk) begin
      cal_done <= (cnt == 1);
      cnt <= cal_start ? 6 : (cnt > 0 ? cnt - 1 : 0);
      // switch is only valid with done; scramble it otherwise
      cal_switch <= (cnt == 1) ? sw_val : ~cal_switch;
   end
endmodule // pfc_cal_model

// ---- verification/pfc_control_bench.sv ----
/* pfc_control_bench: host-side tests of pfc_control.
   assumes the calibration model answers every cal_start. */
`timescale 1ns/1ps
module pfc_control_bench;
   import pfc_pkg::*;
   logic        clk = 0, resetn = 0, sen = 0, sck = 0, sdi = 0, pu = 0, pd = 0;
   logic        cdone, tick, cstart, sdo, mute, cu, cd, hz, bu, bd;
   logic [7:0]  csw, vsw;
   logic [23:0] pint, frac, r;
   logic [5:0]  odiv;
   logic [1:0]  buf_en;
   logic [6:0]  ug, dg, bc;
   logic [11:0] c;
   logic [2:0]  e;
   int          n_errors = 0, checked = 0, cyc = 0, j;
   logic [11:0] pdc [6] = '{12'h060, 12'h040, 12'h020, 12'h000, 12'h200, 12'h400};

   pfc_control DUT (.clk(clk), .resetn(resetn), .sen(sen), .sck(sck), .sdi(sdi), .sdo(sdo),
      .cal_tick(tick), .cal_start(cstart), .cal_done(cdone), .cal_switch(csw),
      .prescaler_int(pint), .dsm_frac(frac), .vco_switch(vsw), .out_divide(odiv),
      .out_mute(mute), .out_buf_en(buf_en), .cp_up_gain(ug), .cp_dn_gain(dg),
      .pump_bias_current(bc), .pump_bias_up_en(bu), .pump_bias_dn_en(bd),
      .phase_detector_up(pu), .phase_detector_dn(pd), .charge_pump_up(cu),
      .charge_pump_dn(cd), .charge_pump_hiz(hz));
   pfc_cal_model CAL (.clk(clk), .cal_start(cstart), .sw_val(8'hA5), .cal_done(cdone),
      .cal_switch(csw));

   always #2.5 clk = ~clk;
   // hang guard, well above the planned run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one frame of nb bits, msb first, sck phases two clocks each
   task automatic xf(input int nb, input logic [30:0] f, output logic [23:0] d);
      sen = 1;
      for (int i = 30; i > 30 - nb; i--) begin
         sck = 0;
         sdi = f[i];
         repeat (2) @(negedge clk);
         if (i < 24) d[i] = sdo;
         sck = 1;
         repeat (2) @(negedge clk);
      end
      sck = 0;
      repeat (2) @(negedge clk);
      sen = 0;
      repeat (4) @(negedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [23:0] v);
      xf(31, {1'b0, a, v}, r);
   endtask
   task automatic rd(input logic [5:0] a, input logic [23:0] x);
      logic [23:0] d;
      xf(31, {1'b1, a, 24'h000000}, d);
      chk(d, x);
   endtask
   task automatic give_verdict;
      $display("TB: errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20) @(negedge clk);
      resetn = 1;
      @(negedge clk);
      chk(24'({tick, hz, mute}), 24'h000005);
      rd(ADR_PHASE_DET_CTL, RST_PHASE_DET_CTL);
      rd(6'h3F, 24'h000000);
      wr(ADR_PUMP_GAIN_OFS, 24'h215932);
      chk(24'({bd, bu, bc, ug, dg}), 24'h215932);
      chk(24'(ug), 24'(GAIN_CODE_1MA));
      wr(ADR_VCO_OUT_DIV, 24'h000001);
      wr(ADR_VCO_OUT_CTL, 24'h0000B0);
      chk(24'({buf_en, odiv, mute}), 24'h000182);
      // every mask setting, and each force bit on its own, against every detector input
      foreach (pdc[k]) begin
         c = pdc[k];
         wr(ADR_PHASE_DET_CTL, 24'(c));
         for (j = 0; j < 4; j++) begin
            {pu, pd} = j[1:0];
            repeat (2) @(negedge clk);
            e = {c[9] | (pu & c[5]), c[10] | (pd & c[6]), ~|{c[10:9], c[6:5]}};
            chk(24'({cu, cd, hz}), 24'(e));
         end
      end
      wr(ADR_INTEGER_DIVIDE, 24'h000064);
      chk(24'({pint, mute}), 24'h000001);
      repeat (12) @(negedge clk);
      chk(pint, 24'h000064);
      chk(24'({vsw, mute}), 24'h00014A);
      rd(ADR_VCO_MAN_TUNE, 24'h00014A);
      wr(ADR_SYNTH_MODE, 24'h000800);
      wr(ADR_FRACTIONAL, 24'h000123);
      repeat (12) @(negedge clk);
      chk(frac, 24'h000123);
      wr(ADR_SYNTH_MODE, 24'h000000);
      wr(ADR_VCO_CAL_CFG, 24'h000800);
      wr(ADR_INTEGER_DIVIDE, 24'h000020);
      chk(24'({pint[7:0], vsw}), 24'h0020A5);
      wr(ADR_VCO_MAN_TUNE, 24'h000078);
      wr(ADR_INTEGER_DIVIDE, 24'h000021);
      chk(24'({pint[7:0], vsw}), 24'h00213C);
      xf(20, {1'b0, ADR_INTEGER_DIVIDE, 24'h000040}, r);
      chk(pint, 24'h000021);
      wr(ADR_PUMP_GAIN_OFS, 24'h000000);
      chk(24'({bd, bu, bc}), 24'h000000);
      give_verdict();
   end
endmodule // pfc_control_bench
